// >>> shared/rdmp_pkg.sv
/*
  Shared constants, types and register map of the discovery mute proxy.
  Assumes one 125 MHz clock shared by the message front end, the reply
  transmitter and the register master.
*/
package rdmp_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int          UID_W       = 48;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          TBL_DEPTH   = 8;
  localparam int          TBL_AW      = 3;
  localparam int          CNT_W       = 4;
  localparam int          SLOT_W      = 5;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFF_CONFIG   = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_OWN_LO   = 8'h08;
  localparam logic [7:0]  OFF_OWN_HI   = 8'h0c;
  localparam logic [7:0]  OFF_BIND_LO  = 8'h10;
  localparam logic [7:0]  OFF_BIND_HI  = 8'h14;
  localparam logic [7:0]  OFF_PX_COUNT = 8'h18;
  localparam logic [7:0]  OFF_PX_INDEX = 8'h1c;
  localparam logic [7:0]  OFF_PX_LO    = 8'h20;
  localparam logic [7:0]  OFF_PX_HI    = 8'h24;

  // CONFIG fields
  localparam int          CFG_PROXY_BIT  = 0;
  localparam int          CFG_SUBDEV_BIT = 1;
  localparam int          CFG_BOOT_BIT   = 2;
  localparam int          CFG_MULTI_BIT  = 3;
  localparam int          CFG_SWRST_BIT  = 8;
  localparam logic [3:0]  CFG_RESET      = 4'h0;
  // STATUS fields
  localparam int          ST_MUTE_BIT    = 0;
  localparam int          ST_BUSY_BIT    = 1;
  localparam int          ST_PMUTE_LSB   = 8;

  // ----------------------------------------------------------------------
  // Control field and acknowledgement lengths
  // ----------------------------------------------------------------------
  localparam int          CTL_MANAGED_BIT = 0;
  localparam int          CTL_SUBDEV_BIT  = 1;
  localparam int          CTL_BOOT_BIT    = 2;
  localparam int          CTL_PROXIED_BIT = 3;
  localparam logic [7:0]  PDL_SINGLE      = 8'h02;
  localparam logic [7:0]  PDL_MULTI       = 8'h08;

  // ----------------------------------------------------------------------
  // Addressing and reply encoding
  // ----------------------------------------------------------------------
  localparam logic [31:0] BCAST_DEV    = 32'hffff_ffff;
  localparam logic [15:0] BCAST_MFR    = 16'hffff;
  localparam logic [7:0]  PREAMBLE     = 8'hfe;
  localparam logic [7:0]  SEPARATOR    = 8'haa;
  localparam logic [7:0]  ENC_HI       = 8'haa;
  localparam logic [7:0]  ENC_LO       = 8'h55;
  localparam logic [4:0]  SLOT_SEP     = 5'h07;
  localparam logic [4:0]  SLOT_EUID    = 5'h08;
  localparam logic [4:0]  SLOT_ECS     = 5'h14;
  localparam logic [4:0]  SLOT_LAST    = 5'h17;
  localparam int          EUID_BYTES   = 12;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MUTE   = 3'b000,
    CMD_UNMUTE = 3'b001,
    CMD_BRANCH = 3'b010,
    CMD_RESET  = 3'b011,
    CMD_OTHER  = 3'b100
  } rdmp_cmd_e;

  typedef enum logic [1:0] {
    RSP_MUTE_ACK   = 2'b00,
    RSP_UNMUTE_ACK = 2'b01,
    RSP_MATCH      = 2'b10
  } rdmp_rsp_e;

  typedef struct packed {
    rdmp_cmd_e          kind;
    logic [UID_W-1:0]   dest;
    logic [UID_W-1:0]   lower;
    logic [UID_W-1:0]   upper;
  } rdmp_cmd_s;

  typedef struct packed {
    rdmp_rsp_e          kind;
    logic               proxied;
    logic [UID_W-1:0]   uid;
    logic [15:0]        ctrl;
    logic [7:0]         pdl;
    logic [UID_W-1:0]   binding;
  } rdmp_rsp_s;

endpackage : rdmp_pkg

// >>> design/rdmp_uid_table.sv
/*
  Table of represented device identifiers, one write port, one read port.
  Assumes the caller waits one cycle for read data, which come from a
  register.
*/
`timescale 1ns/10ps
module rdmp_uid_table (
  input  wire logic                        clock,
  input  wire logic                        wr_en,
  input  wire logic [rdmp_pkg::TBL_AW-1:0] wr_addr,
  input  wire logic [rdmp_pkg::UID_W-1:0]  wr_data,
  input  wire logic                        rd_en,
  input  wire logic [rdmp_pkg::TBL_AW-1:0] rd_addr,
  output      logic [rdmp_pkg::UID_W-1:0]  rd_data
);
  import rdmp_pkg::*;

  logic [UID_W-1:0] mem [TBL_DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : rdmp_uid_table

// >>> design/rdmp_discovery.sv
/*
  Discovery message engine of one responder port that may also proxy for
  up to eight represented devices: mute flags, acknowledgement fields and
  the encoded unique-branch reply stream.
  Assumes a front end on the same clock that has already parsed and
  checked each message, and a transmitter on the same clock that takes
  reply bytes with a ready handshake.
*/
`timescale 1ns/10ps
module rdmp_discovery (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic [rdmp_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rdmp_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output      logic [rdmp_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        cmd_valid,
  input  wire rdmp_pkg::rdmp_cmd_s         cmd,
  output      logic                        cmd_ready,
  output      logic                        rsp_valid,
  output      rdmp_pkg::rdmp_rsp_s         rsp,
  output      logic                        tx_valid,
  output      logic [7:0]                  tx_byte,
  output      logic                        tx_last,
  input  wire logic                        tx_ready
);
  import rdmp_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic addr_hits(input logic [UID_W-1:0] dest,
                                     input logic [UID_W-1:0] uid);
    logic bc;
    bc = (dest[31:0] == BCAST_DEV) &&
         ((dest[47:32] == BCAST_MFR) || (dest[47:32] == uid[47:32]));
    return bc || (dest == uid);
  endfunction : addr_hits

  function automatic logic [7:0] uid_byte(input logic [UID_W-1:0] uid,
                                          input logic [2:0] k);
    return uid[UID_W-1-8*k -: 8];
  endfunction : uid_byte

  function automatic logic [15:0] euid_sum(input logic [UID_W-1:0] uid);
    logic [15:0] s;
    s = 16'h0000;
    for (int k = 0; k < EUID_BYTES/2; k++) begin
      s = s + {8'h00, uid_byte(uid, 3'(k)) | ENC_HI}
            + {8'h00, uid_byte(uid, 3'(k)) | ENC_LO};
    end
    return s;
  endfunction : euid_sum

  function automatic logic [7:0] slot_byte(input logic [SLOT_W-1:0] i,
                                           input logic [UID_W-1:0] uid,
                                           input logic [15:0] cs);
    logic [4:0] e;
    logic [7:0] b;
    e = 5'h00;
    b = 8'h00;
    if (i < SLOT_SEP) begin
      return PREAMBLE;
    end else if (i == SLOT_SEP) begin
      return SEPARATOR;
    end else if (i < SLOT_ECS) begin
      e = i - SLOT_EUID;
      b = uid_byte(uid, e[3:1]);
    end else begin
      e = i - SLOT_ECS;
      b = e[1] ? cs[7:0] : cs[15:8];
    end
    return b | (e[0] ? ENC_LO : ENC_HI);
  endfunction : slot_byte

  function automatic logic [15:0] ctrl_field(input logic proxied,
                                             input logic [3:0] cfg);
    logic [15:0] c;
    c = 16'h0000;
    if (proxied) begin
      c[CTL_PROXIED_BIT] = 1'b1;
    end else begin
      c[CTL_MANAGED_BIT] = cfg[CFG_PROXY_BIT];
      c[CTL_SUBDEV_BIT]  = cfg[CFG_SUBDEV_BIT];
      c[CTL_BOOT_BIT]    = cfg[CFG_BOOT_BIT];
    end
    return c;
  endfunction : ctrl_field

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [3:0]         cfg_reg,     cfg_next;
  logic [UID_W-1:0]   own_reg,     own_next;
  logic [UID_W-1:0]   bind_reg,    bind_next;
  logic [CNT_W-1:0]   pxcnt_reg,   pxcnt_next;
  logic [TBL_AW-1:0]  pxidx_reg,   pxidx_next;
  logic [31:0]        pxlo_reg,    pxlo_next;
  logic [DATA_W-1:0]  rdata_reg,   rdata_next;
  logic               sw_reset;
  logic               tbl_wr;
  logic               own_mute_reg;
  logic [TBL_DEPTH-1:0] pmute_reg;
  logic               busy;

  always_comb begin
    cfg_next   = cfg_reg;
    own_next   = own_reg;
    bind_next  = bind_reg;
    pxcnt_next = pxcnt_reg;
    pxidx_next = pxidx_reg;
    pxlo_next  = pxlo_reg;
    rdata_next = '0;
    sw_reset   = 1'b0;
    tbl_wr     = 1'b0;
    if (reg_write) begin
      case (reg_addr)
        OFF_CONFIG: begin
          cfg_next = reg_wdata[3:0];
          sw_reset = reg_wdata[CFG_SWRST_BIT];
        end
        OFF_OWN_LO:   own_next[31:0]   = reg_wdata;
        OFF_OWN_HI:   own_next[47:32]  = reg_wdata[15:0];
        OFF_BIND_LO:  bind_next[31:0]  = reg_wdata;
        OFF_BIND_HI:  bind_next[47:32] = reg_wdata[15:0];
        OFF_PX_COUNT: begin
          // Four-bit counts above the table depth saturate
          pxcnt_next = (reg_wdata[CNT_W-1:0] > CNT_W'(TBL_DEPTH)) ?
                       CNT_W'(TBL_DEPTH) : reg_wdata[CNT_W-1:0];
        end
        OFF_PX_INDEX: pxidx_next = reg_wdata[TBL_AW-1:0];
        OFF_PX_LO:    pxlo_next  = reg_wdata;
        OFF_PX_HI:    tbl_wr     = 1'b1;
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        OFF_CONFIG:   rdata_next = {28'h0, cfg_reg};
        OFF_STATUS: begin
          rdata_next[ST_MUTE_BIT] = own_mute_reg;
          rdata_next[ST_BUSY_BIT] = busy;
          rdata_next[ST_PMUTE_LSB +: TBL_DEPTH] = pmute_reg;
        end
        OFF_OWN_LO:   rdata_next = own_reg[31:0];
        OFF_OWN_HI:   rdata_next = {16'h0, own_reg[47:32]};
        OFF_BIND_LO:  rdata_next = bind_reg[31:0];
        OFF_BIND_HI:  rdata_next = {16'h0, bind_reg[47:32]};
        OFF_PX_COUNT: rdata_next = {28'h0, pxcnt_reg};
        OFF_PX_INDEX: rdata_next = {29'h0, pxidx_reg};
        OFF_PX_LO:    rdata_next = pxlo_reg;
        default:      rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_reg   <= CFG_RESET;
      own_reg   <= '0;
      bind_reg  <= '0;
      pxcnt_reg <= '0;
      pxidx_reg <= '0;
      pxlo_reg  <= '0;
      rdata_reg <= '0;
    end else begin
      cfg_reg   <= cfg_next;
      own_reg   <= own_next;
      bind_reg  <= bind_next;
      pxcnt_reg <= pxcnt_next;
      pxidx_reg <= pxidx_next;
      pxlo_reg  <= pxlo_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Represented device table
  // ----------------------------------------------------------------------
  logic               mem_rd_en;
  logic [CNT_W-1:0]   idx_reg, idx_next;
  logic [UID_W-1:0]   mem_uid;

  rdmp_uid_table u_table (
    .clock   (clock),
    .wr_en   (tbl_wr),
    .wr_addr (pxidx_reg),
    .wr_data ({reg_wdata[15:0], pxlo_reg}),
    .rd_en   (mem_rd_en),
    .rd_addr (idx_reg[TBL_AW-1:0]),
    .rd_data (mem_uid)
  );

  // ----------------------------------------------------------------------
  // Message engine
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OWN  = 3'b001,
    ST_RD   = 3'b010,
    ST_CHK  = 3'b011,
    ST_TX   = 3'b100
  } rdmp_state_e;

  rdmp_state_e        st_reg, st_next;
  rdmp_cmd_s          cmd_reg, cmd_next;
  logic               own_mute_next;
  logic [TBL_DEPTH-1:0] pmute_next;
  logic               ready_reg, ready_next;
  logic               rspv_reg, rspv_next;
  rdmp_rsp_s          rsp_reg, rsp_next;
  logic               txv_reg, txv_next;
  logic [7:0]         txb_reg, txb_next;
  logic               txl_reg, txl_next;
  logic [SLOT_W-1:0]  slot_reg, slot_next;
  logic [UID_W-1:0]   rep_reg, rep_next;
  logic [15:0]        cs_reg, cs_next;
  logic               start_tx, emit, emit_px;
  logic [UID_W-1:0]   tgt_uid;
  logic               hit, uni, in_rng, muted, last;

  assign busy = (st_reg != ST_IDLE);

  always_comb begin
    st_next       = st_reg;
    cmd_next      = cmd_reg;
    idx_next      = idx_reg;
    own_mute_next = own_mute_reg;
    pmute_next    = pmute_reg;
    rspv_next     = 1'b0;
    rsp_next      = rsp_reg;
    txv_next      = txv_reg;
    txb_next      = txb_reg;
    txl_next      = txl_reg;
    slot_next     = slot_reg;
    rep_next      = rep_reg;
    cs_next       = cs_reg;
    mem_rd_en     = 1'b0;
    start_tx      = 1'b0;
    emit          = 1'b0;
    emit_px       = (st_reg == ST_CHK);
    tgt_uid       = (st_reg == ST_CHK) ? mem_uid : own_reg;
    hit     = addr_hits(cmd_reg.dest, tgt_uid);
    uni     = (cmd_reg.dest == tgt_uid);
    in_rng  = (tgt_uid >= cmd_reg.lower) && (tgt_uid <= cmd_reg.upper);
    muted   = (st_reg == ST_CHK) ? pmute_reg[idx_reg[TBL_AW-1:0]]
                                 : own_mute_reg;
    last    = ((idx_reg + 4'h1) >= pxcnt_reg);
    case (st_reg)
      ST_IDLE: begin
        if (cmd_valid && ready_reg) begin
          cmd_next = cmd;
          st_next  = ST_OWN;
        end
      end
      ST_OWN, ST_CHK: begin
        // The port itself goes first, then the table in index order
        case (cmd_reg.kind)
          CMD_MUTE, CMD_UNMUTE, CMD_RESET: begin
            if (hit) begin
              if (st_reg == ST_CHK) begin
                pmute_next[idx_reg[TBL_AW-1:0]] =
                  (cmd_reg.kind == CMD_MUTE);
              end else begin
                own_mute_next = (cmd_reg.kind == CMD_MUTE);
              end
            end
            // Broadcasts change flags only; nobody acknowledges them
            emit = uni && (cmd_reg.kind != CMD_RESET);
          end
          CMD_BRANCH: begin
            // Own answer only when discoverable as a managed proxy or
            // when no table is in use
            start_tx = in_rng && !muted &&
                       ((st_reg == ST_CHK) || cfg_reg[CFG_PROXY_BIT] ||
                        (pxcnt_reg == 4'h0));
          end
          default: begin
            emit = uni;
          end
        endcase
        if (start_tx || emit) begin
          st_next = ST_IDLE;
        end else if ((st_reg == ST_OWN && pxcnt_reg != 4'h0) ||
                     (st_reg == ST_CHK && !last)) begin
          idx_next = (st_reg == ST_OWN) ? 4'h0 : idx_reg + 4'h1;
          st_next  = ST_RD;
        end else begin
          st_next = ST_IDLE;
        end
      end
      ST_RD: begin
        mem_rd_en = 1'b1;
        st_next   = ST_CHK;
      end
      ST_TX: begin
        if (txv_reg && tx_ready) begin
          if (txl_reg) begin
            txv_next = 1'b0;
            txl_next = 1'b0;
            st_next  = ST_IDLE;
          end else begin
            slot_next = slot_reg + 5'h01;
            txb_next  = slot_byte(slot_next, rep_reg, cs_reg);
            txl_next  = (slot_next == SLOT_LAST);
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
    if (emit) begin
      rspv_next        = 1'b1;
      rsp_next.kind    = (cmd_reg.kind == CMD_MUTE) ? RSP_MUTE_ACK :
                         (cmd_reg.kind == CMD_UNMUTE) ? RSP_UNMUTE_ACK :
                         RSP_MATCH;
      rsp_next.proxied = emit_px;
      rsp_next.uid     = tgt_uid;
      rsp_next.ctrl    = ctrl_field(emit_px, cfg_reg);
      // Binding only describes the physical port, never a represented one
      rsp_next.pdl     = (!emit_px && cfg_reg[CFG_MULTI_BIT]) ?
                         PDL_MULTI : PDL_SINGLE;
      rsp_next.binding = (!emit_px && cfg_reg[CFG_MULTI_BIT]) ?
                         bind_reg : '0;
    end
    if (start_tx) begin
      rep_next  = tgt_uid;
      cs_next   = euid_sum(tgt_uid);
      slot_next = 5'h00;
      txb_next  = PREAMBLE;
      txv_next  = 1'b1;
      txl_next  = 1'b0;
      st_next   = ST_TX;
    end
    if (sw_reset) begin
      own_mute_next = 1'b0;
      pmute_next    = '0;
    end
    ready_next = (st_next == ST_IDLE);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg       <= ST_IDLE;
      cmd_reg      <= '0;
      idx_reg      <= '0;
      own_mute_reg <= 1'b0;
      pmute_reg    <= '0;
      ready_reg    <= 1'b0;
      rspv_reg     <= 1'b0;
      rsp_reg      <= '0;
      txv_reg      <= 1'b0;
      txb_reg      <= 8'h00;
      txl_reg      <= 1'b0;
      slot_reg     <= '0;
      rep_reg      <= '0;
      cs_reg       <= 16'h0000;
    end else begin
      st_reg       <= st_next;
      cmd_reg      <= cmd_next;
      idx_reg      <= idx_next;
      own_mute_reg <= own_mute_next;
      pmute_reg    <= pmute_next;
      ready_reg    <= ready_next;
      rspv_reg     <= rspv_next;
      rsp_reg      <= rsp_next;
      txv_reg      <= txv_next;
      txb_reg      <= txb_next;
      txl_reg      <= txl_next;
      slot_reg     <= slot_next;
      rep_reg      <= rep_next;
      cs_reg       <= cs_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rspv_reg;
  assign rsp       = rsp_reg;
  assign tx_valid  = txv_reg;
  assign tx_byte   = txb_reg;
  assign tx_last   = txl_reg;

endmodule : rdmp_discovery

// >>> bench/rdmp_disc_chk.sv
/*
  Port checker of the discovery engine: acknowledgement fields and the
  encoded reply stream. Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
module rdmp_disc_chk (
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               rsp_valid,
  input wire rdmp_pkg::rdmp_rsp_s rsp,
  input wire logic               tx_valid,
  input wire logic [7:0]         tx_byte,
  input wire logic               tx_last,
  input wire logic               tx_ready
);
  import rdmp_pkg::*;
  // Slot of the byte on offer, counted from accepted handshakes
  logic [4:0] pos_reg;
  logic [4:0] pos_next;
  always_comb begin
    pos_next = pos_reg;
    if (tx_valid && tx_ready)
      pos_next = tx_last ? 5'h00 : pos_reg + 5'h01;
  end
  always_ff @(posedge clock) begin
    if (rst)
      pos_reg <= 5'h00;
    else
      pos_reg <= pos_next;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  ctrl_reserved_a: assert property (rsp_valid |->
    rsp.ctrl[15:4] == 12'h000)
    else $error("control field reserved bits set");
  proxied_flags_a: assert property (rsp_valid && rsp.proxied |->
    rsp.ctrl[3:0] == 4'h8 && rsp.pdl == PDL_SINGLE)
    else $error("represented ack flags wrong");
  own_flag_a: assert property (rsp_valid && !rsp.proxied |->
    !rsp.ctrl[CTL_PROXIED_BIT])
    else $error("own ack carries proxied flag");
  bind_len_a: assert property (rsp_valid |-> rsp.pdl == PDL_MULTI ||
    (rsp.pdl == PDL_SINGLE && rsp.binding == 48'h0))
    else $error("ack length and binding disagree");
  ack_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("ack pulse longer than one cycle");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte) && $stable(tx_last))
    else $error("reply byte changed while stalled");
  preamble_a: assert property (tx_valid && pos_reg < SLOT_SEP |->
    tx_byte == PREAMBLE)
    else $error("preamble byte wrong");
  enc_pair_a: assert property (tx_valid && pos_reg >= SLOT_EUID |->
    (tx_byte | (pos_reg[0] ? ENC_HI : ENC_LO)) == 8'hff)
    else $error("encoded byte not ORed correctly");
  last_slot_a: assert property (tx_valid && tx_last |->
    pos_reg == SLOT_LAST)
    else $error("reply length not 24 bytes");
endmodule : rdmp_disc_chk

bind rdmp_discovery rdmp_disc_chk chk (.clock(clock), .rst(rst),
  .rsp_valid(rsp_valid), .rsp(rsp), .tx_valid(tx_valid),
  .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));

// >>> bench/rdmp_ctl_model.sv
/*
  Controller model on the reply stream: takes bytes, decodes each frame.
  Assumes reply bytes on the bench clock with a ready handshake.
*/
`timescale 1ns/10ps
module rdmp_ctl_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_last,
  output      logic        tx_ready,
  output      logic [7:0]  frames,
  output      logic        ok,
  output      logic [47:0] uid
);
  logic [7:0]  slot [24];
  logic [15:0] sum;
  logic        phase;
  int          n;
  // Slow mode stalls every other cycle to exercise the hold
  assign tx_ready = !slow || phase;
  // Sum of the twelve stored encoded identifier bytes
  always_comb begin
    sum = 16'h0000;
    for (int i = 0; i < 12; i++) begin
      sum = sum + 16'(slot[8 + i]);
    end
  end
  always_ff @(posedge clock) begin
    phase <= rst ? 1'b0 : !phase;
    if (rst) begin
      n <= 0;
      frames <= 8'h00;
      ok <= 1'b0;
      uid <= 48'h0;
    end else if (tx_valid && tx_ready) begin
      // The first byte of each frame counts as a reply, corrupt or not
      if (n == 0)
        frames <= frames + 8'h01;
      if (n < 24)
        slot[n] <= tx_byte;
      n <= tx_last ? 0 : n + 1;
      if (tx_last) begin
        for (int i = 0; i < 6; i++)
          uid[47 - 8 * i -: 8] <= slot[8 + 2 * i] & slot[9 + 2 * i];
        // Final byte is still on the wires, not yet stored
        ok <= sum == {slot[20] & slot[21], slot[22] & tx_byte};
      end
    end
  end
endmodule : rdmp_ctl_model

// >>> bench/rdmp_discovery_test.sv
/*
  Self-checking bench of the discovery engine.
  Assumes the controller model takes the reply stream.
*/
`timescale 1ns/10ps
module rdmp_discovery_test;
  import rdmp_pkg::*;
  localparam logic [47:0] U = 48'h1234_5678_9abc;
  localparam logic [47:0] B = 48'h1234_5678_9a00;
  localparam logic [47:0] ALL = 48'hffff_ffff_ffff;
  localparam logic [47:0] PX [2] = '{48'h0abc_0000_0011, 48'h0abc_0000_0022};
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        cmd_valid = 1'b0;
  rdmp_cmd_s   cmd = '0;
  logic        cmd_ready, rsp_valid, tx_valid, tx_last, tx_ready, ok;
  rdmp_rsp_s   rsp, rq;
  logic [7:0]  tx_byte, frames;
  logic [47:0] uid;
  logic        slow = 1'b0;
  int          nrsp = 0;
  int          failures = 0;
  int          samples_checked = 0;
  rdmp_discovery DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready));
  rdmp_ctl_model ctl (.clock(clock), .rst(rst), .slow(slow),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready), .frames(frames), .ok(ok), .uid(uid));
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    if (rsp_valid === 1'b1) begin
      rq <= rsp;
      nrsp <= nrsp + 1;
    end
  end
  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [127:0] e, g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", 128'(e), 128'(reg_rdata & m));
    @(posedge clock);
  endtask : rd
  task automatic await(input int lim);
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (cmd_ready !== 1'b1 && i < lim);
    if (cmd_ready !== 1'b1) begin
      failures++;
      wrap_up();
    end
  endtask : await
  task automatic go(input rdmp_cmd_e k, input logic [47:0] d, lo, hi,
                    input int er, ef);
    int         r0;
    logic [7:0] f0;
    r0 = nrsp;
    f0 = frames;
    cmd <= '{k, d, lo, hi};
    cmd_valid <= 1'b1;
    await(50);
    cmd_valid <= 1'b0;
    await(200);
    repeat (2) @(posedge clock);
    chk("responses", 128'(er), 128'(nrsp - r0));
    chk("frames", 128'(ef), 128'(frames - f0));
  endtask : go
  task automatic ak(input rdmp_rsp_e k, input logic px,
                    input logic [47:0] u, input logic [15:0] c,
                    input logic [7:0] p, input logic [47:0] b);
    rdmp_rsp_s e;
    e = '{k, px, u, c, p, b};
    chk("rsp", 128'(e), 128'(rq));
  endtask : ak
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(OFF_CONFIG, 32'hffff_ffff, 32'h0);
    rd(OFF_STATUS, 32'hffff_ffff, 32'h0);
    rd(8'h40, 32'hffff_ffff, 32'h0);
    wr(OFF_OWN_LO, U[31:0]);
    wr(OFF_OWN_HI, {16'h0, U[47:32]});
    wr(OFF_CONFIG, 32'h2);
    go(CMD_MUTE, U, '0, '0, 1, 0);
    ak(RSP_MUTE_ACK, 1'b0, U, 16'h0002, PDL_SINGLE, '0);
    rd(OFF_STATUS, 32'h1, 32'h1);
    go(CMD_BRANCH, ALL, '0, ALL, 0, 0);
    go(CMD_OTHER, U, '0, '0, 1, 0);
    chk("rsp.uid", 128'(U), 128'(rq.uid));
    go(CMD_UNMUTE, ALL, '0, '0, 0, 0);
    rd(OFF_STATUS, 32'h1, 32'h0);
    slow <= 1'b1;
    go(CMD_BRANCH, ALL, U, U, 0, 1);
    chk("ok", 128'(1'b1), 128'(ok));
    chk("uid", 128'(U), 128'(uid));
    go(CMD_BRANCH, ALL, U + 48'h1, ALL, 0, 0);
    slow <= 1'b0;
    wr(OFF_BIND_LO, B[31:0]);
    wr(OFF_BIND_HI, {16'h0, B[47:32]});
    wr(OFF_CONFIG, 32'hd);
    go(CMD_UNMUTE, U, '0, '0, 1, 0);
    ak(RSP_UNMUTE_ACK, 1'b0, U, 16'h0005, PDL_MULTI, B);
    wr(OFF_PX_COUNT, 32'h2);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_PX_INDEX, 32'(i));
      wr(OFF_PX_LO, PX[i][31:0]);
      wr(OFF_PX_HI, {16'h0, PX[i][47:32]});
    end
    go(CMD_MUTE, PX[1], '0, '0, 1, 0);
    ak(RSP_MUTE_ACK, 1'b1, PX[1], 16'h0008, PDL_SINGLE, '0);
    rd(OFF_STATUS, 32'hff00, 32'h0200);
    go(CMD_BRANCH, ALL, '0, ALL, 0, 1);
    chk("uid", 128'(U), 128'(uid));
    go(CMD_MUTE, uid, '0, '0, 1, 0);
    go(CMD_BRANCH, ALL, '0, ALL, 0, 1);
    chk("uid", 128'(PX[0]), 128'(uid));
    go(CMD_MUTE, ALL, '0, '0, 0, 0);
    rd(OFF_STATUS, 32'hff01, 32'h0301);
    go(CMD_BRANCH, ALL, '0, ALL, 0, 0);
    go(CMD_RESET, U, '0, '0, 0, 0);
    rd(OFF_STATUS, 32'h1, 32'h0);
    wr(OFF_CONFIG, 32'h10d);
    rd(OFF_STATUS, 32'hff01, 32'h0);
    go(CMD_UNMUTE, ALL, '0, '0, 0, 0);
    go(CMD_MUTE, U, '0, '0, 1, 0);
    go(CMD_MUTE, PX[0], '0, '0, 1, 0);
    go(CMD_BRANCH, ALL, '0, ALL, 0, 1);
    chk("uid", 128'(PX[1]), 128'(uid));
    wrap_up();
  end
endmodule : rdmp_discovery_test
